/* shared/btv_pkg.sv */
// Constants and carrier types for the step-down target voltage register bank.
// Assumes a single 100 MHz clock domain and a byte-wide register access port.
package btv_pkg;

  // Counts of regulators and of alternate scaling registers.
  localparam int BTV_NUM_BUCKS = 4;
  localparam int BTV_NUM_ALT   = 2;
  localparam int BTV_CODE_W    = 8;
  localparam int BTV_VOLT_W    = 16;
  localparam int BTV_OTP_W     = 5;

  // Register byte addresses.
  localparam logic [7:0] BTV_ADDR_BUCK0_TARGET = 8'h16;
  localparam logic [7:0] BTV_ADDR_BUCK1_TARGET = 8'h17;
  localparam logic [7:0] BTV_ADDR_BUCK2_TARGET = 8'h18;
  localparam logic [7:0] BTV_ADDR_BUCK3_TARGET = 8'h19;
  localparam logic [7:0] BTV_ADDR_BUCK0_ALT    = 8'h1B;
  localparam logic [7:0] BTV_ADDR_BUCK1_ALT    = 8'h1C;

  // Reset values of the alternate registers and field layout of the normal target registers.
  localparam logic [7:0] BTV_BUCK0_ALT_RESET = 8'h20;
  localparam logic [7:0] BTV_BUCK1_ALT_RESET = 8'h10;
  localparam logic [1:0] BTV_LOW_BITS_RESET  = 2'h0;
  localparam logic       BTV_TOP_BIT_RESET   = 1'b0;
  localparam logic [7:0] BTV_UNMAPPED_READ   = 8'h00;

  // Code ranges: below the minimum is reserved, above a maximum is refused.
  localparam logic [7:0] BTV_CODE_MIN_VALID = 8'h02;
  localparam logic [7:0] BTV_BUCK0_CODE_MAX = 8'h40;
  localparam logic [7:0] BTV_BUCK1_CODE_MAX = 8'h4C;
  localparam logic [7:0] BTV_WIDE_CODE_MAX  = 8'hFF;

  // Decoded voltage in units of 100 uV: 0.6250 V at the minimum code, 12.5 mV a step.
  localparam logic [15:0] BTV_VOLT_BASE = 16'h186A;
  localparam logic [15:0] BTV_VOLT_STEP = 16'h007D;
  localparam logic [15:0] BTV_VOLT_NONE = 16'h0000;

  // One register access from the serial front end.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } btv_reg_req_t;

  // Alternate-mode setup of one selector pin.
  typedef struct packed {
    logic alt_mode_enable;
    logic polarity;
  } btv_sel_cfg_t;

endpackage : btv_pkg

/* hw/btv_pin_sync.sv */
// Three-stage synchroniser with agreement filter for one selector pin.
// Assumes the pin is asynchronous to SYS_CLK_I; output is a registered level.
module btv_pin_sync (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic resetn_i,
  // Raw pin and filtered level.
  input  wire logic pin_i,
  output logic      level_o
);
  import btv_pkg::*;

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  // Shift the pin in; the level moves only when stages two and three agree.
  always_comb begin
    next_stage = {stage[1:0], pin_i};
    next_level = level_o;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  // Register the chain and the filtered level.
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stage   <= 3'h0;
      level_o <= 1'b0;
    end else begin
      stage   <= next_stage;
      level_o <= next_level;
    end
  end

  // A level change must be backed by two agreeing late stages.
  AST_SYNC_AGREE : assert property (@(posedge clk_i) disable iff (!resetn_i)
    (level_o != $past(level_o)) |-> ($past(stage[1]) == $past(stage[2]) && level_o == $past(stage[2])))
    else $error("Selector level changed without stage agreement.");

endmodule : btv_pin_sync

/* hw/btv_target_regs.sv */
// Target voltage register bank for four step-down regulators with pin-selected alternates.
// Assumes a serial front end delivers decoded byte accesses on REG_REQ_I, and that
// RESETN_I is the global shutdown, with the one-time-programmed fields steady at release.

// What this block does
// - Buck2 and buck3 full-byte targets at 0x18, 0x19.
// - Buck0 normal target register at 0x16.
// - Buck1 normal target register at 0x17.
// - Buck0 alternate target at 0x1B, resets 0x20.
// - Buck1 alternate target at 0x1C, resets 0x10.
// - Selector A switches only in alternate mode.
// - Active selector A picks buck0 alternate target.
// - Selector B switches only in alternate mode.
// - Active selector B picks buck1 alternate target.
// - Inactive selector B picks buck1 normal target.
// - Buck0 writes of 0x41 to 0xFF ignored.
// - Buck1 writes of 0x4D to 0xFF ignored.
// - Buck2/3 decode 0.625 V upward, 12.5 mV steps.
// - Buck0 decodes 0.625 V to 1.400 V.
// - Buck1 decodes 0.625 V to 1.550 V.
// - Shutdown reloads normal targets from programmed bits.
module btv_target_regs (
  // Clock and global shutdown.
  input  wire logic                                              SYS_CLK_I,
  input  wire logic                                              RESETN_I,
  // Register access port.
  input  wire btv_pkg::btv_reg_req_t                             REG_REQ_I,
  output logic [7:0]                                             REG_RDATA_O,
  output logic                                                   REG_RVALID_O,
  // Programmed reset fields.
  input  wire logic [btv_pkg::BTV_NUM_BUCKS-1:0][btv_pkg::BTV_OTP_W-1:0] OTP_MID_I,
  input  wire logic                                              OTP_BUCK3_TOP_I,
  // Selector pins and their setup.
  input  wire btv_pkg::btv_sel_cfg_t [btv_pkg::BTV_NUM_ALT-1:0]  SEL_CFG_I,
  input  wire logic [btv_pkg::BTV_NUM_ALT-1:0]                   SELECTOR_PIN_I,
  // Regulator drive.
  output logic [btv_pkg::BTV_NUM_BUCKS-1:0][btv_pkg::BTV_CODE_W-1:0] TARGET_CODE_O,
  output logic [btv_pkg::BTV_NUM_BUCKS-1:0][btv_pkg::BTV_VOLT_W-1:0] TARGET_VOLT_O,
  output logic [btv_pkg::BTV_NUM_BUCKS-1:0]                      TARGET_DEFINED_O
);
  import btv_pkg::*;

  // True when a code lies in the defined range up to a given ceiling.
  function automatic logic code_defined(input logic [7:0] code, input logic [7:0] max_code);
    code_defined = (code >= BTV_CODE_MIN_VALID) && (code <= max_code);
  endfunction : code_defined

  // Linear decode of a code into 100 uV units, zero when undefined.
  function automatic logic [15:0] decode_volt(input logic [7:0] code, input logic [7:0] max_code);
    logic [31:0] prod;
    prod = 32'(16'(code) - 16'(BTV_CODE_MIN_VALID)) * 32'(BTV_VOLT_STEP);
    if (code_defined(code, max_code)) begin
      decode_volt = BTV_VOLT_BASE + prod[15:0];
    end else begin
      decode_volt = BTV_VOLT_NONE;
    end
  endfunction : decode_volt

  // Highest code each regulator accepts and decodes.
  localparam logic [BTV_NUM_BUCKS-1:0][7:0] MAX_CODE = {BTV_WIDE_CODE_MAX, BTV_WIDE_CODE_MAX,
                                                        BTV_BUCK1_CODE_MAX, BTV_BUCK0_CODE_MAX};
  localparam logic [BTV_NUM_BUCKS-1:0][7:0] TARGET_ADDR = {BTV_ADDR_BUCK3_TARGET, BTV_ADDR_BUCK2_TARGET,
                                                           BTV_ADDR_BUCK1_TARGET, BTV_ADDR_BUCK0_TARGET};
  localparam logic [BTV_NUM_ALT-1:0][7:0] ALT_ADDR  = {BTV_ADDR_BUCK1_ALT, BTV_ADDR_BUCK0_ALT};
  localparam logic [BTV_NUM_ALT-1:0][7:0] ALT_RESET = {BTV_BUCK1_ALT_RESET, BTV_BUCK0_ALT_RESET};

  logic [BTV_NUM_BUCKS-1:0][7:0] buck_target;
  logic [BTV_NUM_BUCKS-1:0][7:0] next_buck_target;
  logic [BTV_NUM_ALT-1:0][7:0]   alt_target;
  logic [BTV_NUM_ALT-1:0][7:0]   next_alt_target;
  logic [BTV_NUM_BUCKS-1:0][7:0] reset_target;
  logic [BTV_NUM_ALT-1:0]        sel_level;
  logic [BTV_NUM_ALT-1:0]        use_alt;
  logic [7:0]                    next_rdata;
  logic                          next_rvalid;
  logic [BTV_NUM_BUCKS-1:0][7:0] next_code;
  logic [BTV_NUM_BUCKS-1:0][15:0] next_volt;
  logic [BTV_NUM_BUCKS-1:0]      next_defined;

  // Selector pins cross into the clock domain before they steer anything.
  genvar g;
  generate
    for (g = 0; g < BTV_NUM_ALT; g++) begin : g_sel
      btv_pin_sync u_sync (
        .clk_i    (SYS_CLK_I),
        .resetn_i (RESETN_I),
        .pin_i    (SELECTOR_PIN_I[g]),
        .level_o  (sel_level[g])
      );
      // Polarity high means the pin is active high; alternate mode gates it all.
      assign use_alt[g] = SEL_CFG_I[g].alt_mode_enable
                          && (sel_level[g] == SEL_CFG_I[g].polarity);
    end
  endgenerate

  // Shutdown values: low bits clear, middle bits programmed, top bit programmed on buck3 only.
  always_comb begin
    for (int i = 0; i < BTV_NUM_BUCKS; i++) begin
      reset_target[i] = {BTV_TOP_BIT_RESET, OTP_MID_I[i], BTV_LOW_BITS_RESET};
    end
    reset_target[BTV_NUM_BUCKS-1][7] = OTP_BUCK3_TOP_I;
  end

  // Register writes; codes above a regulator's ceiling leave the register untouched.
  always_comb begin
    next_buck_target = buck_target;
    next_alt_target  = alt_target;
    if (REG_REQ_I.wr) begin
      for (int i = 0; i < BTV_NUM_BUCKS; i++) begin
        if (REG_REQ_I.addr == TARGET_ADDR[i] && REG_REQ_I.wdata <= MAX_CODE[i]) begin
          next_buck_target[i] = REG_REQ_I.wdata;
        end
      end
      for (int j = 0; j < BTV_NUM_ALT; j++) begin
        if (REG_REQ_I.addr == ALT_ADDR[j] && REG_REQ_I.wdata <= MAX_CODE[j]) begin
          next_alt_target[j] = REG_REQ_I.wdata;
        end
      end
    end
  end

  // Store the register file; shutdown loads programmed and fixed values.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      buck_target <= reset_target;
      alt_target  <= ALT_RESET;
    end else begin
      buck_target <= next_buck_target;
      alt_target  <= next_alt_target;
    end
  end

  // Read path: unmapped addresses read as zero, so a probe never sees stale data.
  always_comb begin
    next_rdata  = BTV_UNMAPPED_READ;
    next_rvalid = REG_REQ_I.rd;
    for (int i = 0; i < BTV_NUM_BUCKS; i++) begin
      if (REG_REQ_I.addr == TARGET_ADDR[i]) begin
        next_rdata = buck_target[i];
      end
    end
    for (int j = 0; j < BTV_NUM_ALT; j++) begin
      if (REG_REQ_I.addr == ALT_ADDR[j]) begin
        next_rdata = alt_target[j];
      end
    end
    if (!REG_REQ_I.rd) begin
      next_rdata = REG_RDATA_O;
    end
  end

  // Register the read answer.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      REG_RDATA_O  <= BTV_UNMAPPED_READ;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RDATA_O  <= next_rdata;
      REG_RVALID_O <= next_rvalid;
    end
  end

  // Pick each regulator's code and decode it; the regulator sees it one cycle later.
  always_comb begin
    next_code = buck_target;
    for (int j = 0; j < BTV_NUM_ALT; j++) begin
      if (use_alt[j]) begin
        next_code[j] = alt_target[j];
      end else begin
        next_code[j] = buck_target[j];
      end
    end
    for (int i = 0; i < BTV_NUM_BUCKS; i++) begin
      next_volt[i]    = decode_volt(next_code[i], MAX_CODE[i]);
      next_defined[i] = code_defined(next_code[i], MAX_CODE[i]);
    end
  end

  // Drive the regulators from flops so the analog side never sees decode glitches.
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      TARGET_CODE_O    <= '0;
      TARGET_VOLT_O    <= '0;
      TARGET_DEFINED_O <= '0;
    end else begin
      TARGET_CODE_O    <= next_code;
      TARGET_VOLT_O    <= next_volt;
      TARGET_DEFINED_O <= next_defined;
    end
  end

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  // Helper: low in shutdown and until the first clock edge after release, high from then on.
  logic past_valid;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RESETN_I) begin
      past_valid <= 1'b0;
    end else begin
      past_valid <= 1'b1;
    end
  end

  AST_WIDE_WRITE : assert property (
    (REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK2_TARGET) |=> (buck_target[2] == $past(REG_REQ_I.wdata)))
    else $error("Buck2 target did not take a written code.");

  AST_BUCK0_NORMAL_WRITE : assert property (
    (REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK0_TARGET && REG_REQ_I.wdata <= BTV_BUCK0_CODE_MAX)
    |=> (buck_target[0] == $past(REG_REQ_I.wdata)))
    else $error("Buck0 target did not take a legal code.");

  AST_BUCK1_NORMAL_WRITE : assert property (
    (REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK1_TARGET && REG_REQ_I.wdata <= BTV_BUCK1_CODE_MAX)
    |=> (buck_target[1] == $past(REG_REQ_I.wdata)))
    else $error("Buck1 target did not take a legal code.");

  AST_ALT_RESET : assert property (
    (!past_valid) |-> (alt_target[0] == BTV_BUCK0_ALT_RESET && alt_target[1] == BTV_BUCK1_ALT_RESET))
    else $error("Alternate targets missed their reset values.");

  AST_BUCK0_REFUSE : assert property (
    (REG_REQ_I.wr && (REG_REQ_I.addr == BTV_ADDR_BUCK0_TARGET || REG_REQ_I.addr == BTV_ADDR_BUCK0_ALT)
     && REG_REQ_I.wdata > BTV_BUCK0_CODE_MAX) |=> ($stable(buck_target[0]) && $stable(alt_target[0])))
    else $error("Buck0 accepted a reserved code.");

  AST_BUCK1_REFUSE : assert property (
    (REG_REQ_I.wr && (REG_REQ_I.addr == BTV_ADDR_BUCK1_TARGET || REG_REQ_I.addr == BTV_ADDR_BUCK1_ALT)
     && REG_REQ_I.wdata > BTV_BUCK1_CODE_MAX) |=> ($stable(buck_target[1]) && $stable(alt_target[1])))
    else $error("Buck1 accepted a reserved code.");

  AST_SEL_A_ALT : assert property (
    (use_alt[0]) |=> (TARGET_CODE_O[0] == $past(alt_target[0])))
    else $error("Active selector A did not pick the alternate target.");

  AST_SEL_B_NORMAL : assert property (
    (!use_alt[1]) |=> (TARGET_CODE_O[1] == $past(buck_target[1])))
    else $error("Inactive selector B did not pick the buck1 target.");

  AST_MODE_GATE : assert property (
    (!SEL_CFG_I[1].alt_mode_enable) |=> (TARGET_CODE_O[1] == $past(buck_target[1])))
    else $error("Selector B switched outside alternate mode.");

  AST_DECODE : assert property (
    (TARGET_CODE_O[3] == BTV_WIDE_CODE_MAX) |-> (TARGET_VOLT_O[3] == 16'h93F3 && TARGET_DEFINED_O[3]))
    else $error("Top buck3 code decoded wrongly.");

  AST_RESERVED_LOW : assert property (
    (TARGET_CODE_O[0] < BTV_CODE_MIN_VALID) |-> (TARGET_VOLT_O[0] == BTV_VOLT_NONE && !TARGET_DEFINED_O[0]))
    else $error("Reserved buck0 code decoded as a voltage.");

  AST_BUCK1_TOP : assert property (
    (TARGET_CODE_O[1] == BTV_BUCK1_CODE_MAX) |-> (TARGET_VOLT_O[1] == 16'h3C8C))
    else $error("Buck1 top code did not decode to 1.5500 V.");

  AST_FOLLOW : assert property (
    (past_valid && REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK3_TARGET) |=> ##1
    (TARGET_CODE_O[3] == $past(REG_REQ_I.wdata, 2)))
    else $error("Buck3 drive did not follow a write.");

  // Alternate and buck3 writes land in the cycle after they are taken.
  AST_ALT0_WRITE : assert property (
    (REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK0_ALT && REG_REQ_I.wdata <= BTV_BUCK0_CODE_MAX)
    |=> (alt_target[0] == $past(REG_REQ_I.wdata)))
    else $error("Buck0 alternate target did not take a legal code.");

  AST_ALT1_WRITE : assert property (
    (REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK1_ALT && REG_REQ_I.wdata <= BTV_BUCK1_CODE_MAX)
    |=> (alt_target[1] == $past(REG_REQ_I.wdata)))
    else $error("Buck1 alternate target did not take a legal code.");

  AST_BUCK3_WRITE : assert property (
    (REG_REQ_I.wr && REG_REQ_I.addr == BTV_ADDR_BUCK3_TARGET) |=> (buck_target[3] == $past(REG_REQ_I.wdata)))
    else $error("Buck3 target did not take a written code.");

  // A read answers one cycle later with the byte stored when it was taken.
  AST_READ_ANSWER : assert property (
    (REG_REQ_I.rd && REG_REQ_I.addr == BTV_ADDR_BUCK0_TARGET)
    |=> (REG_RVALID_O && REG_RDATA_O == $past(buck_target[0])))
    else $error("Buck0 target read did not answer with the stored byte.");

  // Shutdown values are rebuilt field by field here, not taken from the load logic.
  AST_SHUTDOWN_LOAD : assert property (
    (!past_valid) |->
    (buck_target[0] == {BTV_TOP_BIT_RESET, OTP_MID_I[0], BTV_LOW_BITS_RESET}
     && buck_target[1] == {BTV_TOP_BIT_RESET, OTP_MID_I[1], BTV_LOW_BITS_RESET}
     && buck_target[2] == {BTV_TOP_BIT_RESET, OTP_MID_I[2], BTV_LOW_BITS_RESET}
     && buck_target[3] == {OTP_BUCK3_TOP_I, OTP_MID_I[3], BTV_LOW_BITS_RESET}))
    else $error("Normal targets missed their shutdown values.");

  // Selector A inactive and gated off, and selector B active from its synchronised level and polarity.
  AST_SEL_A_NORMAL : assert property (
    (!use_alt[0]) |=> (TARGET_CODE_O[0] == $past(buck_target[0])))
    else $error("Inactive selector A did not pick the buck0 target.");

  AST_SEL_A_GATE : assert property (
    (!SEL_CFG_I[0].alt_mode_enable) |=> (TARGET_CODE_O[0] == $past(buck_target[0])))
    else $error("Selector A switched outside alternate mode.");

  AST_SEL_B_ALT : assert property (
    (SEL_CFG_I[1].alt_mode_enable && sel_level[1] == SEL_CFG_I[1].polarity)
    |=> (TARGET_CODE_O[1] == $past(alt_target[1])))
    else $error("Active selector B did not pick the alternate target.");

endmodule : btv_target_regs

/* verif/btv_host_model.sv */
// Host-side model that issues single byte register accesses to the target bank.
// Assumes the bench calls its task and that requests launch at the falling clock edge.
module btv_host_model (
  // Clock.
  input  wire logic            clk_i,
  // Register access request.
  output btv_pkg::btv_reg_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import btv_pkg::*;

  // The port idles with no strobe so nothing is taken between calls.
  initial begin
    req_o = '0;
  end

  // One access is held for exactly one rising edge, then released; a second call waits
  // for the next falling edge, so the request never changes twice in one time step.
  task automatic access(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: w, rd: r, addr: a, wdata: d};
    @(negedge clk_i);
    req_o = '0;
  endtask : access
endmodule : btv_host_model

/* verif/buck_target_voltage_regs_tb.sv */
// Self-checking bench for the step-down target voltage register bank.
// Assumes the host model drives the register port and the bench drives pins and programmed bits.
module buck_target_voltage_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import btv_pkg::*;

  // Stimulus and observed outputs.
  logic                  clk     = 1'b0;
  logic                  resetn  = 1'b0;
  btv_reg_req_t          req;
  logic [7:0]            rdata;
  logic                  rvalid;
  logic [3:0][4:0]       otp     = '0;
  logic                  otp_top = 1'b0;
  btv_sel_cfg_t [1:0]    sel_cfg = '0;
  logic [1:0]            pin     = '0;
  logic [3:0][7:0]       code;
  logic [3:0][15:0]      volt;
  logic [3:0]            defd;
  int                    failures = 0;
  int                    n_tests  = 0;
  int                    cycles   = 0;
  logic [31:0]           rng      = 32'd61008;
  logic [7:0]            exp_q[$];
  logic [7:0]            mx [4]   = '{8'h40, 8'h4C, 8'hFF, 8'hFF};
  logic [7:0]            ad [6]   = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h1B, 8'h1C};
  logic [7:0]            cur [6];

  // Clock at 100 MHz.
  always #5 clk = ~clk;

  btv_host_model host_u (.clk_i(clk), .req_o(req));

  btv_target_regs dut_u (
    .SYS_CLK_I(clk), .RESETN_I(resetn), .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .OTP_MID_I(otp), .OTP_BUCK3_TOP_I(otp_top), .SEL_CFG_I(sel_cfg), .SELECTOR_PIN_I(pin),
    .TARGET_CODE_O(code), .TARGET_VOLT_O(volt), .TARGET_DEFINED_O(defd)
  );

  // Xorshift generator with a fixed seed, so every run repeats.
  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : nxt

  // Expected decode in 100 uV units: 0.625 V at code 0x02, 12.5 mV a step.
  function automatic logic [15:0] volt_of(input logic [7:0] c, input logic [7:0] m);
    if (c < 8'h02 || c > m) return 16'h0000;
    return 16'h186A + 16'(c - 8'h02) * 16'h007D;
  endfunction : volt_of

  task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, 1'b0, a, d);
  endtask : wr

  // The expected byte is queued before the request so the monitor finds it in order.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  // One more edge lets the registered regulator outputs follow their source.
  task automatic check_out(input int b, input logic [7:0] c);
    @(negedge clk);
    check("code", 16'(c), 16'(code[b]));
    check("volt", volt_of(c, mx[b]), volt[b]);
    check("defined", 16'(c >= 8'h02 && c <= mx[b]), 16'(defd[b]));
  endtask : check_out

  // Shutdown reloads the normal targets from the programmed bits and the alternates to constants.
  task automatic do_reset();
    logic [7:0] e;
    @(negedge clk);
    resetn = 1'b0;
    otp = 20'(nxt());
    otp_top = 1'(nxt());
    // A later shutdown loads a reserved buck0 code, so the undefined decode is exercised too.
    if (n_tests > 0) otp[0] = '0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      e = {(i == 3) ? otp_top : 1'b0, otp[i], 2'b00};
      rd(ad[i], e);
      check_out(i, e);
    end
    rd(8'h1B, 8'h20);
    rd(8'h1C, 8'h10);
    rd(8'h1A, 8'h00);
  endtask : do_reset

  // Read data is compared against the oldest queued expectation when it appears.
  always @(negedge clk) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) check("rvalid", 16'h0000, 16'h0001);
      else check("rdata", 16'(exp_q.pop_front()), 16'(rdata));
    end
  end

  // A hang is cut short well above the fewer than two hundred cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    int o;
    do_reset();
    // Ceiling accepted, one above it refused where the ceiling is below 0xFF, then a random valid code that stays.
    for (int r = 0; r < 6; r++) begin
      o = (r < 4) ? r : r - 4;
      wr(ad[r], mx[o]);
      rd(ad[r], mx[o]);
      if (r < 4) check_out(o, mx[o]);
      if (mx[o] != 8'hFF) begin
        wr(ad[r], mx[o] + 8'h01);
        rd(ad[r], mx[o]);
      end
      cur[r] = 8'(2 + nxt() % (int'(mx[o]) - 1));
      wr(ad[r], cur[r]);
      rd(ad[r], cur[r]);
      if (r < 4) check_out(o, cur[r]);
    end
    // Each selector in both polarities: inactive, active, then alternate mode turned off.
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 2; p++) begin
        sel_cfg[s] = '{alt_mode_enable: 1'b1, polarity: p[0]};
        pin[s] = ~p[0];
        repeat (4) @(negedge clk);
        check_out(s, cur[s]);
        pin[s] = p[0];
        repeat (4) @(negedge clk);
        check_out(s, cur[s + 4]);
        sel_cfg[s].alt_mode_enable = 1'b0;
        @(negedge clk);
        check_out(s, cur[s]);
        pin[s] = 1'b0;
      end
    end
    // A second shutdown in mid-run must reload everything again.
    do_reset();
    repeat (3) @(negedge clk);
    check("pending", 16'h0000, 16'(exp_q.size()));
    print_verdict();
  end
endmodule : buck_target_voltage_regs_tb
